// [include/channel_pkg.sv]
// Constants, modes and carrier structs for the channel unit.
// Assumes a single system clock; all ports are plain signals, no register bus.
// Function
// - Time base is 24 bits, free-running wrap
// - CPU read of A delays capture
// - Pulse capture: lead to B, trail to A
// - Period capture on two same-polarity edges
// - A match leads, B match trails output
// - Immediate or next-period update of B
// - B match only after A match
package channel_pkg;
  localparam int TB_WIDTH = 24;
  localparam logic [TB_WIDTH-1:0] TB_RESET = 24'h000000;
  localparam logic [TB_WIDTH-1:0] TB_STEP = 24'h000001;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_PULSE_WIDTH = 2'h1,
    MODE_PERIOD = 2'h3,
    MODE_EDGE_PWM = 2'h2
  } mode_e;

  // Edge PWM sequencing: waiting for A, then for B
  typedef enum logic {
    SEQ_WAIT_A = 1'b0,
    SEQ_WAIT_B = 1'b1
  } seq_e;

  // Pulse capture sequencing
  typedef enum logic {
    CAP_WAIT_LEAD = 1'b0,
    CAP_WAIT_TRAIL = 1'b1
  } cap_e;

  typedef struct packed {
    mode_e mode;
    logic polarity;
    logic next_period;
  } cfg_s;

  typedef struct packed {
    logic wr_a;
    logic wr_b;
    logic [TB_WIDTH-1:0] wdata;
    logic rd_a;
    logic force_a;
    logic force_b;
    logic flag_clr;
  } cpu_s;
endpackage : channel_pkg

// [rtl/channel_unit.sv]
// Timer channel: pulse-width capture, period capture and edge PWM output.
// Assumes software follows the coherent-read and forced-match procedures.
`timescale 1ns/1ps
module channel_unit
  import channel_pkg::*;
#(
  parameter int W = TB_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire cfg_s cfg,
  input wire cpu_s cpu,
  input wire logic chan_in,
  output logic [W-1:0] reg_a,
  output logic [W-1:0] reg_b,
  output logic [W-1:0] count,
  output logic chan_flag,
  output logic chan_out
);
  logic rise, fall;
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] a_q, a_d;
  logic [W-1:0] b_q, b_d;
  logic [W-1:0] b_buf_q, b_buf_d;
  logic b_pend_q, b_pend_d;
  logic [W-1:0] pend_a_q, pend_a_d;
  logic pend_valid_q, pend_valid_d;
  logic flag_q, flag_d;
  logic out_q, out_d;
  seq_e seq_q, seq_d;
  cap_e cap_q, cap_d;
  logic lead, trail, period_edge;
  logic match_a, match_b;
  logic cap_a_req;
  logic [W-1:0] cap_a_val;
  logic cap_event;

  // Pin crosses into clk here; each edge shows two clocks late, which
  // cancels in A minus B because both captured edges share that delay
  edge_detect_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(chan_in),
    .rise(rise),
    .fall(fall)
  );

  // Leading edge follows pulse polarity: high pulse leads on rise
  assign lead = cfg.polarity ? rise : fall;
  assign trail = cfg.polarity ? fall : rise;
  assign period_edge = cfg.polarity ? rise : fall;

  // Comparator matches, or forced matches acting the same way.
  // Equality only: a value written behind the count waits for a full wrap,
  // which is why software forces the match after such a write
  assign match_a = (cnt_q == a_q) | cpu.force_a;
  assign match_b = (cnt_q == b_q) | cpu.force_b;

  // Capture steering and sequencing
  always_comb begin
    cap_d = cap_q;
    b_d = b_q;
    a_d = a_q;
    cap_a_req = 1'b0;
    cap_a_val = cnt_q;
    cap_event = 1'b0;
    b_buf_d = b_buf_q;
    b_pend_d = b_pend_q;
    case (cfg.mode)
      // Lead parks the start time in B; the trail completes the pair in A
      MODE_PULSE_WIDTH: begin
        if (cap_q == CAP_WAIT_LEAD) begin
          if (lead) begin
            b_d = cnt_q;
            cap_d = CAP_WAIT_TRAIL;
          end
        end else if (trail) begin
          cap_a_req = 1'b1;
          cap_event = 1'b1;
          cap_d = CAP_WAIT_LEAD;
        end
      end
      MODE_PERIOD: begin
        // Old A moves to B, new edge time to A
        // A capture still parked behind a read counts as the old A
        if (period_edge) begin
          b_d = pend_valid_q ? pend_a_q : a_q;
          cap_a_req = 1'b1;
          cap_event = 1'b1;
        end
        cap_d = CAP_WAIT_LEAD;
      end
      MODE_EDGE_PWM: begin
        cap_d = CAP_WAIT_LEAD;
        if (cpu.wr_a) begin
          a_d = cpu.wdata;
        end
        if (cpu.wr_b && !cfg.next_period) begin
          b_d = cpu.wdata;
        end else if (cpu.wr_b) begin
          b_buf_d = cpu.wdata;
          b_pend_d = 1'b1;
        end
        // Buffered B loads at the B match that ends the period, so the
        // new trailing edge first applies in the following period
        if (seq_q == SEQ_WAIT_B && match_b && b_pend_q && !(cpu.wr_b && cfg.next_period)) begin
          b_d = b_buf_q;
          b_pend_d = 1'b0;
        end
      end
      default: begin
        cap_d = CAP_WAIT_LEAD;
      end
    endcase
  end

  // Hardware writes to A yield to a CPU read in the same cycle.
  // The blocked capture is parked and lands in the first cycle without a
  // read; B writes do not wait for the read, so software can see a stale A beside a new B
  always_comb begin
    pend_a_d = pend_a_q;
    pend_valid_d = pend_valid_q;
    if (cap_a_req) begin
      pend_a_d = cap_a_val;
      pend_valid_d = 1'b1;
    end
    if (!cpu.rd_a && pend_valid_q && !cap_a_req) begin
      pend_valid_d = 1'b0;
    end else if (!cpu.rd_a && cap_a_req) begin
      pend_valid_d = 1'b0;
    end
  end

  // Mode decode shared by the A write path and the output sequencer
  function automatic logic is_pwm(input mode_e m);
    return m == MODE_EDGE_PWM;
  endfunction : is_pwm

  // Final A value: capture lands only when no CPU read is in progress
  logic [W-1:0] a_next;
  always_comb begin
    a_next = a_d;
    if (!is_pwm(cfg.mode) && !cpu.rd_a) begin
      if (cap_a_req) begin
        a_next = cap_a_val;
      end else if (pend_valid_q) begin
        a_next = pend_a_q;
      end
    end
  end

  // Time base free-runs and wraps at 24 bits
  // No prescaler: one tick per clock, so a forced match acts within a tick
  always_comb begin
    cnt_d = cnt_q + W'(TB_STEP);
  end

  // Edge PWM: ordered matching drives the output
  // Outside this mode the output parks at its inactive level
  always_comb begin
    seq_d = seq_q;
    out_d = out_q;
    if (is_pwm(cfg.mode)) begin
      if (seq_q == SEQ_WAIT_A && match_a) begin
        out_d = cfg.polarity;
        seq_d = SEQ_WAIT_B;
      end else if (seq_q == SEQ_WAIT_B && match_b) begin
        out_d = ~cfg.polarity;
        seq_d = SEQ_WAIT_A;
      end
    end else begin
      seq_d = SEQ_WAIT_A;
      out_d = ~cfg.polarity;
    end
  end

  // Sticky flag; a capture in the clearing cycle wins
  // Set beats clear so an event landing during the clear is never lost
  always_comb begin
    flag_d = flag_q;
    if (cpu.flag_clr) begin
      flag_d = 1'b0;
    end
    if (cap_event) begin
      flag_d = 1'b1;
    end
  end

  // Registers
  // Reset is synchronous, so every register clears on the same edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= W'(TB_RESET);
      a_q <= W'(TB_RESET);
      b_q <= W'(TB_RESET);
      b_buf_q <= W'(TB_RESET);
      b_pend_q <= 1'b0;
      pend_a_q <= W'(TB_RESET);
      pend_valid_q <= 1'b0;
      flag_q <= 1'b0;
      out_q <= 1'b0;
      seq_q <= SEQ_WAIT_A;
      cap_q <= CAP_WAIT_LEAD;
    end else begin
      cnt_q <= cnt_d;
      a_q <= a_next;
      b_q <= b_d;
      b_buf_q <= b_buf_d;
      b_pend_q <= b_pend_d;
      pend_a_q <= pend_a_d;
      pend_valid_q <= pend_valid_d;
      flag_q <= flag_d;
      out_q <= out_d;
      seq_q <= seq_d;
      cap_q <= cap_d;
    end
  end

  assign reg_a = a_q;
  assign reg_b = b_q;
  assign count = cnt_q;
  assign chan_flag = flag_q;
  assign chan_out = out_q;
endmodule : channel_unit

// [rtl/edge_detect_sync.sv]
// Two-flop synchroniser for the channel input pin plus edge detect.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module edge_detect_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  // Next values; sync_q and last_q feed the edge logic
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : edge_detect_sync

// [testbench/channel_unit_asserts.sv]
// Port-level checks for the channel unit.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module channel_unit_asserts
  import channel_pkg::*;
#(
  parameter int W = TB_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire cfg_s cfg,
  input wire cpu_s cpu,
  input wire logic chan_in,
  input wire logic [W-1:0] reg_a,
  input wire logic [W-1:0] reg_b,
  input wire logic [W-1:0] count,
  input wire logic chan_flag,
  input wire logic chan_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pwm;
  // PWM checks assume A and B hold different values
  assign pwm = cfg.mode == MODE_EDGE_PWM;
  count_step_a: assert property ($past(rst_n) |-> count == $past(count) + 1'h1)
    else $error("time base did not step by one");
  lead_edge_a: assert property (pwm && count == reg_a && !cpu.force_b |=> chan_out == cfg.polarity)
    else $error("A match did not lead");
  trail_edge_a: assert property (pwm && count == reg_b && chan_out == cfg.polarity && !cpu.force_a
    |=> chan_out != cfg.polarity)
    else $error("B match did not trail");
  ordered_b_a: assert property (pwm && count == reg_b && count != reg_a && chan_out != cfg.polarity
    && !cpu.force_a |=> chan_out != cfg.polarity)
    else $error("B match acted before A match");
  forced_lead_a: assert property (pwm && cpu.force_a && !cpu.force_b |=> chan_out == cfg.polarity)
    else $error("forced A match had no effect");
  flag_hold_a: assert property (chan_flag && !cpu.flag_clr |=> chan_flag)
    else $error("flag dropped without a clear");
  read_wins_a: assert property (cfg.mode[0] && cpu.rd_a |=> $stable(reg_a))
    else $error("capture into A during a read");
  capture_flag_a: assert property (cfg.mode[0] && $changed(reg_a) |-> chan_flag)
    else $error("capture without flag");
endmodule : channel_unit_asserts
bind channel_unit channel_unit_asserts #(.W(W)) chk (.clk, .rst_n, .cfg, .cpu, .chan_in, .reg_a,
  .reg_b, .count, .chan_flag, .chan_out);

// [testbench/pin_model.sv]
// Far-side pin model: a repeating pulse on the channel input.
// Assumes the bench holds run low between tests so the pin rests low.
`timescale 1ns/1ps
module pin_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] high_len,
  output logic pin
);
  int n = 0;
  initial pin = 1'h0;
  // Low 20 cycles, then high for high_len, 40-cycle period
  always @(posedge clk) begin
    n <= run ? (n + 1) % 40 : 0;
    pin <= #1 run && n >= 20 && n < 20 + high_len;
  end
endmodule : pin_model

// [testbench/tb_top.sv]
// Self-checking bench: both capture modes and edge PWM output.
// Assumes the pin model on chan_in and the bound checker.
`timescale 1ns/1ps
module tb_top
  import channel_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic run = 1'h0;
  logic [7:0] high_len = 8'h0C;
  cfg_s cfg = '0;
  cpu_s cpu = '0;
  logic chan_in;
  logic [23:0] reg_a, reg_b, count;
  logic chan_flag, chan_out;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  channel_unit dut (.clk, .rst_n, .cfg, .cpu, .chan_in, .reg_a, .reg_b, .count, .chan_flag,
    .chan_out);
  pin_model far (.clk, .run, .high_len, .pin(chan_in));
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One-cycle command; an idle cycle follows so no field is driven twice at once
  task automatic send(input cpu_s c);
    cpu = c;
    @(posedge clk) #1;
    cpu = '0;
    @(posedge clk) #1;
  endtask : send
  task automatic wait_for(input logic want, input bit on_flag);
    for (int i = 0; i < 300 && (on_flag ? chan_flag : chan_out) !== want; i++) @(posedge clk) #1;
  endtask : wait_for
  // First capture is dropped: its B may hold a stale value
  task automatic measure(input mode_e m, input logic pol, input logic [23:0] exp);
    logic [23:0] b1, a1, a2, b2, w;
    cfg = '{m, pol, 1'h0};
    run = 1'h1;
    wait_for(1'h1, 1);
    send({2'h0, 24'h0, 4'h1});
    wait_for(1'h1, 1);
    check("flag set", {23'h0, chan_flag}, 24'h1);
    b1 = reg_b;
    cpu.rd_a = 1'h1;
    a1 = reg_a;
    @(posedge clk) #1;
    a2 = reg_a;
    cpu.rd_a = 1'h0;
    b2 = reg_b;
    // Low 24 bits of A minus B already carry the wrap correction
    w = (a1 != a2 && b1 == b2) ? a1 - b1 : a2 - b2;
    check("width", w, exp);
    send({2'h0, 24'h0, 4'h1});
    check("flag clear", {23'h0, chan_flag}, 24'h0);
    run = 1'h0;
    repeat (50) @(posedge clk) #1;
    $display("capture test done");
  endtask : measure
  // Period capture with a read held across the edge: the capture must wait
  task automatic read_collide();
    logic [23:0] a0;
    cfg = '{MODE_PERIOD, 1'h1, 1'h0};
    run = 1'h1;
    wait_for(1'h1, 1);
    send({2'h0, 24'h0, 4'h1});
    a0 = reg_a;
    cpu.rd_a = 1'h1;
    wait_for(1'h1, 1);
    check("A held", reg_a, a0);
    check("old A to B", reg_b, a0);
    cpu.rd_a = 1'h0;
    @(posedge clk) #1;
    check("late A", reg_a - reg_b, 24'h000028);
    send({2'h0, 24'h0, 4'h1});
    run = 1'h0;
    repeat (50) @(posedge clk) #1;
    $display("read collision test done");
  endtask : read_collide
  task automatic pwm_run();
    // Park at the inactive level first: capture tests may leave the output high
    cfg = '{MODE_IDLE, 1'h1, 1'h0};
    @(posedge clk) #1;
    check("idle level", {23'h0, chan_out}, 24'h0);
    cfg = '{MODE_EDGE_PWM, 1'h1, 1'h0};
    send({2'h2, count + 24'h14, 4'h0});
    send({2'h1, count + 24'h28, 4'h0});
    wait_for(1'h1, 0);
    check("lead", count, reg_a + 24'h1);
    wait_for(1'h0, 0);
    check("trail", count, reg_b + 24'h1);
    send({2'h2, count - 24'h5, 4'h0});
    send({2'h0, 24'h0, 4'h4});
    check("forced lead", {23'h0, chan_out}, 24'h1);
    send({2'h1, count - 24'h5, 4'h0});
    send({2'h0, 24'h0, 4'h2});
    check("forced trail", {23'h0, chan_out}, 24'h0);
    send({2'h1, count + 24'h6, 4'h0});
    repeat (10) @(posedge clk) #1;
    check("unordered B", {23'h0, chan_out}, 24'h0);
    // A skipped B match must not use up the period: the next A still leads
    send({2'h2, count + 24'h8, 4'h0});
    wait_for(1'h1, 0);
    check("lead after skip", count, reg_a + 24'h1);
    $display("pwm test done");
  endtask : pwm_run
  // Next-period mode: a B write waits for the B match that ends the period
  task automatic buffered_b();
    logic [23:0] b_old, b_new;
    cfg = '{MODE_IDLE, 1'h1, 1'h0};
    @(posedge clk) #1;
    cfg = '{MODE_EDGE_PWM, 1'h1, 1'h0};
    send({2'h2, count + 24'h14, 4'h0});
    send({2'h1, count + 24'h28, 4'h0});
    b_old = reg_b;
    cfg.next_period = 1'h1;
    wait_for(1'h1, 0);
    b_new = count + 24'h0A;
    send({2'h1, b_new, 4'h0});
    check("B held", reg_b, b_old);
    wait_for(1'h0, 0);
    check("old trail", count, b_old + 24'h1);
    check("B loaded", reg_b, b_new);
    $display("buffered B test done");
  endtask : buffered_b
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Whole run needs under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    measure(MODE_PULSE_WIDTH, 1'h1, 24'h00000C);
    measure(MODE_PULSE_WIDTH, 1'h0, 24'h00001C);
    measure(MODE_PERIOD, 1'h1, 24'h000028);
    measure(MODE_PERIOD, 1'h0, 24'h000028);
    read_collide();
    pwm_run();
    buffered_b();
    complete_run();
  end
endmodule : tb_top
